// ### design/multifunction_pin_control.sv
// Role selection, drive and readback for five shared pins
//
// Summary of operation
// - ISA: pin4 is LA17 input; else enable/data
// - Data bit 4 reads live pin4 level
// - Status-change: BALE input in ISA, output otherwise
// - Function 1, data 0: status-change masked
// - Wakeup clear resets status-change data bit
// - Function 0: pin is inverse of data
// - Status-change data reads inverse pin level
// - ISA: pin0 is refresh input; else enable/data
// - Data bit 0 reads live pin0 level
// - ISA select C drives IRQ12, totem or open-drain
// - Data bit 1 reads live pin1 level
// - CTS gate ANDs pin1 with transmit start
// - Edge select sets pin1 interrupt flag
// - Pin7: function input, IRQ11, or enable/data
// - Data bit 7 reads live pin7 level
// - Input releases, totem drives, open-drain pulls low
//
// Local design decisions: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
module multifunction_pin_control (
  // Clock and reset
  input  wire logic                    ref_clk,
  input  wire logic                    reset_n,
  // Bus-select strap, high selects PCMCIA
  input  wire logic                    busSelectStrap,
  // Register port
  input  wire pin_mux_pkg::reg_req_s   regReq,
  output logic [7:0]                   regRdata,
  // Plug and Play interrupt routing and requests
  input  wire pin_mux_pkg::pnp_irq_s   pnpIrq,
  input  wire logic                    irq12Request,
  input  wire logic                    irq11Request,
  // Card wakeup status bit
  input  wire logic                    cardWakeup,
  // Shared pins
  input  wire logic [4:0]              pinIn,
  output pin_mux_pkg::pin_drive_s      pinDrive,
  // Transmit start and controller interrupt
  output logic                         transmitGo,
  output logic                         externalControllerInterrupt
);
  pin_mux_pkg::top_state_s state;
  pin_mux_pkg::top_state_s next_state;
  logic                    u1Hit;
  logic [7:0]              liveUserBits;
  logic                    wrHit [8];

  pin_event_detect edge_unit (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .level   (pinIn[pin_mux_pkg::PIN_USER1]),
    .edgeSel (pin_mux_pkg::edge_sel_e'(state.edgeSel)),
    .hit     (u1Hit)
  );

  always_comb begin
    liveUserBits = 8'h00;
    liveUserBits[pin_mux_pkg::BIT_USER0] = pinIn[pin_mux_pkg::PIN_USER0];
    liveUserBits[pin_mux_pkg::BIT_USER1] = pinIn[pin_mux_pkg::PIN_USER1];
    liveUserBits[pin_mux_pkg::BIT_USER4] = pinIn[pin_mux_pkg::PIN_USER4];
    liveUserBits[pin_mux_pkg::BIT_USER7] = pinIn[pin_mux_pkg::PIN_USER7];
  end

  always_comb begin
    wrHit[0] = regReq.wr && regReq.addr == pin_mux_pkg::ADDR_USER_ENABLE;
    wrHit[1] = regReq.wr && regReq.addr == pin_mux_pkg::ADDR_USER_DATA;
    wrHit[2] = regReq.wr && regReq.addr == pin_mux_pkg::ADDR_FUNCTION_B;
    wrHit[3] = regReq.wr && regReq.addr == pin_mux_pkg::ADDR_FUNCTION_C;
    wrHit[4] = regReq.wr && regReq.addr == pin_mux_pkg::ADDR_MEM_IF_PIN;
    wrHit[5] = regReq.wr && regReq.addr == pin_mux_pkg::ADDR_CONFIG_A;
    wrHit[6] = regReq.wr && regReq.addr == pin_mux_pkg::ADDR_INT_STATUS;
    wrHit[7] = regReq.wr && regReq.addr == pin_mux_pkg::ADDR_TX_CONTROL;
  end

  always_comb begin
    next_state = state;
    // Strap is caught on the first edge after reset release
    if (!state.strapTaken) begin
      next_state.pcmciaMode = busSelectStrap;
      next_state.strapTaken = 1'b1;
    end
    // Register writes
    if (wrHit[0]) begin
      next_state.userEnable = regReq.wdata & pin_mux_pkg::USER_BIT_MASK;
    end
    if (wrHit[1]) begin
      next_state.userData = regReq.wdata & pin_mux_pkg::USER_BIT_MASK;
    end
    if (wrHit[2]) begin
      next_state.scFunction = regReq.wdata[pin_mux_pkg::BIT_SC_FUNC];
    end
    if (wrHit[3]) begin
      next_state.u7Function = regReq.wdata[pin_mux_pkg::BIT_U7_FUNC];
    end
    if (wrHit[5]) begin
      next_state.ctsEnable = regReq.wdata[pin_mux_pkg::BIT_CTS_EN];
      next_state.edgeSel   = regReq.wdata[pin_mux_pkg::BIT_EDGE_HI:pin_mux_pkg::BIT_EDGE_LO];
    end
    if (wrHit[7]) begin
      next_state.txStart = regReq.wdata[pin_mux_pkg::BIT_TX_START];
    end
    // Wakeup falling clears the unmask bit; a same-cycle write still lands
    next_state.wakePrev = cardWakeup;
    if (state.wakePrev && !cardWakeup) begin
      next_state.scData = 1'b0;
    end
    if (wrHit[4]) begin
      next_state.scData = regReq.wdata[pin_mux_pkg::BIT_SC_DATA];
    end
    // Interrupt flag: write 1 clears, a new edge wins over the clear
    if (wrHit[6] && regReq.wdata[pin_mux_pkg::BIT_U1_FLAG]) begin
      next_state.u1Flag = 1'b0;
    end
    if (u1Hit) begin
      next_state.u1Flag = 1'b1;
    end
    next_state.ecInt = next_state.u1Flag;
    // Transmit start gating
    if (state.ctsEnable) begin
      next_state.txGo = pinIn[pin_mux_pkg::PIN_USER1] & state.txStart;
    end else begin
      next_state.txGo = state.txStart;
    end
    // Read data, one cycle after the strobe
    next_state.rdData = 8'h00;
    if (regReq.rd) begin
      unique case (regReq.addr)
        pin_mux_pkg::ADDR_USER_ENABLE: next_state.rdData = state.userEnable;
        pin_mux_pkg::ADDR_USER_DATA:   next_state.rdData = liveUserBits;
        pin_mux_pkg::ADDR_FUNCTION_B:
          next_state.rdData[pin_mux_pkg::BIT_SC_FUNC] = state.scFunction;
        pin_mux_pkg::ADDR_FUNCTION_C:
          next_state.rdData[pin_mux_pkg::BIT_U7_FUNC] = state.u7Function;
        pin_mux_pkg::ADDR_MEM_IF_PIN:
          next_state.rdData[pin_mux_pkg::BIT_SC_DATA] = ~pinIn[pin_mux_pkg::PIN_SC];
        pin_mux_pkg::ADDR_CONFIG_A: begin
          next_state.rdData[pin_mux_pkg::BIT_CTS_EN] = state.ctsEnable;
          next_state.rdData[pin_mux_pkg::BIT_EDGE_HI:pin_mux_pkg::BIT_EDGE_LO] = state.edgeSel;
        end
        pin_mux_pkg::ADDR_INT_STATUS:
          next_state.rdData[pin_mux_pkg::BIT_U1_FLAG] = state.u1Flag;
        pin_mux_pkg::ADDR_TX_CONTROL:
          next_state.rdData[pin_mux_pkg::BIT_TX_START] = state.txStart;
        default: next_state.rdData = 8'h00;
      endcase
    end
    // Pin roles; enableN low means driving, high means released
    next_state.drive.level   = '0;
    next_state.drive.enableN = '1;
    if (state.pcmciaMode && state.userEnable[pin_mux_pkg::BIT_USER0]) begin
      next_state.drive.enableN[pin_mux_pkg::PIN_USER0] = 1'b0;
      next_state.drive.level[pin_mux_pkg::PIN_USER0] = state.userData[pin_mux_pkg::BIT_USER0];
    end
    if (state.pcmciaMode && state.userEnable[pin_mux_pkg::BIT_USER4]) begin
      next_state.drive.enableN[pin_mux_pkg::PIN_USER4] = 1'b0;
      next_state.drive.level[pin_mux_pkg::PIN_USER4] = state.userData[pin_mux_pkg::BIT_USER4];
    end
    if (!state.pcmciaMode && pnpIrq.select == pin_mux_pkg::IRQ_SEL_12
        && pnpIrq.kind == pin_mux_pkg::IRQ_TYPE_TOTEM) begin
      next_state.drive.enableN[pin_mux_pkg::PIN_USER1] = 1'b0;
      next_state.drive.level[pin_mux_pkg::PIN_USER1] = irq12Request;
    end else if (!state.pcmciaMode && pnpIrq.select == pin_mux_pkg::IRQ_SEL_12
                 && pnpIrq.kind == pin_mux_pkg::IRQ_TYPE_OPEN) begin
      next_state.drive.enableN[pin_mux_pkg::PIN_USER1] = ~irq12Request;
    end else if (state.userEnable[pin_mux_pkg::BIT_USER1]) begin
      next_state.drive.enableN[pin_mux_pkg::PIN_USER1] = 1'b0;
      next_state.drive.level[pin_mux_pkg::PIN_USER1] = state.userData[pin_mux_pkg::BIT_USER1];
    end
    if (state.u7Function) begin
      next_state.drive.enableN[pin_mux_pkg::PIN_USER7] = 1'b1;
    end else if (!state.pcmciaMode) begin
      if (pnpIrq.select == pin_mux_pkg::IRQ_SEL_11
          && pnpIrq.kind == pin_mux_pkg::IRQ_TYPE_TOTEM) begin
        next_state.drive.enableN[pin_mux_pkg::PIN_USER7] = 1'b0;
        next_state.drive.level[pin_mux_pkg::PIN_USER7] = irq11Request;
      end else if (pnpIrq.select == pin_mux_pkg::IRQ_SEL_11
                   && pnpIrq.kind == pin_mux_pkg::IRQ_TYPE_OPEN) begin
        next_state.drive.enableN[pin_mux_pkg::PIN_USER7] = ~irq11Request;
      end
    end else if (state.userEnable[pin_mux_pkg::BIT_USER7]) begin
      next_state.drive.enableN[pin_mux_pkg::PIN_USER7] = 1'b0;
      next_state.drive.level[pin_mux_pkg::PIN_USER7] = state.userData[pin_mux_pkg::BIT_USER7];
    end
    // Status-change pin is active low
    if (state.pcmciaMode) begin
      next_state.drive.enableN[pin_mux_pkg::PIN_SC] = 1'b0;
      if (state.scFunction) begin
        next_state.drive.level[pin_mux_pkg::PIN_SC] = ~(state.scData & cardWakeup);
      end else begin
        next_state.drive.level[pin_mux_pkg::PIN_SC] = ~state.scData;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state               <= '0;
      state.userEnable    <= pin_mux_pkg::RESET_BYTE;
      state.userData      <= pin_mux_pkg::RESET_BYTE;
      state.edgeSel       <= pin_mux_pkg::RESET_EDGE;
      state.drive.enableN <= '1;
    end else begin
      state <= next_state;
    end
  end

  always_comb begin
    regRdata                    = state.rdData;
    pinDrive                    = state.drive;
    transmitGo                  = state.txGo;
    externalControllerInterrupt = state.ecInt;
  end

  a_sc_read_inverse: assert property (@(posedge ref_clk) disable iff (!reset_n)
    regReq.rd && regReq.addr == pin_mux_pkg::ADDR_MEM_IF_PIN
    |=> regRdata[0] == ~$past(pinIn[pin_mux_pkg::PIN_SC]))
    else $error("status-change data read is not the inverse pin level");

  a_user_read_live: assert property (@(posedge ref_clk) disable iff (!reset_n)
    regReq.rd && regReq.addr == pin_mux_pkg::ADDR_USER_DATA
    |=> regRdata[0] == $past(pinIn[0]) && regRdata[1] == $past(pinIn[1])
        && regRdata[4] == $past(pinIn[2]) && regRdata[7] == $past(pinIn[3]))
    else $error("user data read is not the live pin level");

  a_user0_drive: assert property (@(posedge ref_clk) disable iff (!reset_n)
    state.strapTaken && state.pcmciaMode && state.userEnable[0]
    |=> !pinDrive.enableN[0] && pinDrive.level[0] == $past(state.userData[0]))
    else $error("user pin 0 not driven from its data bit");

  a_isa_user4_input: assert property (@(posedge ref_clk) disable iff (!reset_n)
    state.strapTaken && !state.pcmciaMode |=> pinDrive.enableN[2])
    else $error("user pin 4 driven in ISA mode");

  a_sc_masked: assert property (@(posedge ref_clk) disable iff (!reset_n)
    state.pcmciaMode && state.scFunction && !state.scData
    |=> !pinDrive.enableN[4] && pinDrive.level[4])
    else $error("status-change pin asserted while masked");

  a_sc_wake_clear: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $fell(cardWakeup) && !(regReq.wr && regReq.addr == pin_mux_pkg::ADDR_MEM_IF_PIN)
    |=> !state.scData)
    else $error("unmask bit survived wakeup clear");

  a_tx_gate: assert property (@(posedge ref_clk) disable iff (!reset_n)
    state.ctsEnable |=> transmitGo == $past(pinIn[1] & state.txStart))
    else $error("transmit start not gated by pin 1");

  a_edge_flag_set: assert property (@(posedge ref_clk) disable iff (!reset_n)
    state.edgeSel == 2'h1 && $rose(pinIn[1]) |=> externalControllerInterrupt)
    else $error("rising edge did not raise the pin 1 flag");

  a_edge_disabled: assert property (@(posedge ref_clk) disable iff (!reset_n)
    state.edgeSel == 2'h0 && !state.u1Flag |=> !state.u1Flag)
    else $error("pin 1 flag set while edge detect disabled");

  a_user7_fn_input: assert property (@(posedge ref_clk) disable iff (!reset_n)
    state.u7Function |=> pinDrive.enableN[3])
    else $error("user pin 7 driven while its function bit is set");

  a_irq12_open_drain: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !state.pcmciaMode && pnpIrq.select == 4'hc && pnpIrq.kind == 2'h1
    |=> pinDrive.level[1] == 1'b0 && pinDrive.enableN[1] == ~$past(irq12Request))
    else $error("IRQ12 open-drain drive wrong");

  a_isa_sc_input: assert property (@(posedge ref_clk) disable iff (!reset_n)
    state.strapTaken && !state.pcmciaMode |=> pinDrive.enableN[4])
    else $error("status-change pin driven in ISA mode");

  a_sc_drive_inverse: assert property (@(posedge ref_clk) disable iff (!reset_n)
    state.pcmciaMode && !state.scFunction
    |=> !pinDrive.enableN[4] && pinDrive.level[4] == !$past(state.scData))
    else $error("status-change pin is not the inverse data bit");

  a_isa_user0_input: assert property (@(posedge ref_clk) disable iff (!reset_n)
    state.strapTaken && !state.pcmciaMode |=> pinDrive.enableN[0])
    else $error("user pin 0 driven in ISA mode");

  a_user4_drive: assert property (@(posedge ref_clk) disable iff (!reset_n)
    state.pcmciaMode && state.userEnable[4]
    |=> !pinDrive.enableN[2] && pinDrive.level[2] == $past(state.userData[4]))
    else $error("user pin 4 not driven from its data bit");

  a_irq12_totem: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !state.pcmciaMode && pnpIrq.select == pin_mux_pkg::IRQ_SEL_12
    && pnpIrq.kind == pin_mux_pkg::IRQ_TYPE_TOTEM
    |=> !pinDrive.enableN[1] && pinDrive.level[1] == $past(irq12Request))
    else $error("IRQ12 totem-pole drive wrong");

  a_irq11_totem: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !state.u7Function && !state.pcmciaMode && pnpIrq.select == pin_mux_pkg::IRQ_SEL_11
    && pnpIrq.kind == pin_mux_pkg::IRQ_TYPE_TOTEM
    |=> !pinDrive.enableN[3] && pinDrive.level[3] == $past(irq11Request))
    else $error("IRQ11 totem-pole drive wrong");

  a_irq11_open_drain: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !state.u7Function && !state.pcmciaMode && pnpIrq.select == pin_mux_pkg::IRQ_SEL_11
    && pnpIrq.kind == pin_mux_pkg::IRQ_TYPE_OPEN
    |=> pinDrive.level[3] == 1'b0 && pinDrive.enableN[3] == ~$past(irq11Request))
    else $error("IRQ11 open-drain drive wrong");

  a_tx_ungated: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !state.ctsEnable |=> transmitGo == $past(state.txStart))
    else $error("transmit start does not follow its bit");

  a_edge_fall_set: assert property (@(posedge ref_clk) disable iff (!reset_n)
    state.edgeSel == 2'h2 && $fell(pinIn[1]) |=> externalControllerInterrupt)
    else $error("falling edge did not raise the pin 1 flag");
endmodule

// ### design/pin_event_detect.sv
// Shared constants and types, plus the edge detector for user pin 1
`timescale 1ns/1ps
package pin_mux_pkg;
  // Register offsets (byte addresses)
  localparam logic [7:0] ADDR_USER_ENABLE  = 8'h00;
  localparam logic [7:0] ADDR_USER_DATA    = 8'h04;
  localparam logic [7:0] ADDR_FUNCTION_B   = 8'h08;
  localparam logic [7:0] ADDR_FUNCTION_C   = 8'h0c;
  localparam logic [7:0] ADDR_MEM_IF_PIN   = 8'h10;
  localparam logic [7:0] ADDR_CONFIG_A     = 8'h14;
  localparam logic [7:0] ADDR_INT_STATUS   = 8'h18;
  localparam logic [7:0] ADDR_TX_CONTROL   = 8'h1c;
  // Field positions
  localparam int BIT_USER0      = 0;
  localparam int BIT_USER1      = 1;
  localparam int BIT_USER4      = 4;
  localparam int BIT_USER7      = 7;
  localparam int BIT_SC_FUNC    = 0;
  localparam int BIT_U7_FUNC    = 7;
  localparam int BIT_SC_DATA    = 0;
  localparam int BIT_CTS_EN     = 0;
  localparam int BIT_EDGE_LO    = 3;
  localparam int BIT_EDGE_HI    = 4;
  localparam int BIT_U1_FLAG    = 3;
  localparam int BIT_TX_START   = 0;
  localparam logic [7:0] USER_BIT_MASK = 8'h93;
  // Pin slots in the pin vectors
  localparam int PIN_USER0 = 0;
  localparam int PIN_USER1 = 1;
  localparam int PIN_USER4 = 2;
  localparam int PIN_USER7 = 3;
  localparam int PIN_SC    = 4;
  localparam int PIN_COUNT = 5;
  // Plug and Play interrupt codes
  localparam logic [3:0] IRQ_SEL_12     = 4'hc;
  localparam logic [3:0] IRQ_SEL_11     = 4'hb;
  localparam logic [1:0] IRQ_TYPE_TOTEM = 2'h2;
  localparam logic [1:0] IRQ_TYPE_OPEN  = 2'h1;
  // Reset values
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [1:0] RESET_EDGE = 2'h0;

  typedef enum logic [1:0] {EDGE_OFF, EDGE_RISE, EDGE_FALL, EDGE_BOTH} edge_sel_e;

  typedef struct packed {
    logic [PIN_COUNT-1:0] level;
    logic [PIN_COUNT-1:0] enableN;
  } pin_drive_s;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_s;

  typedef struct packed {
    logic [3:0] select;
    logic [1:0] kind;
  } pnp_irq_s;

  typedef struct packed {
    logic pcmciaMode;
    logic strapTaken;
    logic [7:0] userEnable;
    logic [7:0] userData;
    logic scFunction;
    logic scData;
    logic u7Function;
    logic ctsEnable;
    logic txStart;
    logic [1:0] edgeSel;
    logic u1Flag;
    logic wakePrev;
    logic [7:0] rdData;
    pin_drive_s drive;
    logic txGo;
    logic ecInt;
  } top_state_s;

  typedef struct packed {
    logic prev;
  } edge_state_s;
endpackage

module pin_event_detect (
  // Clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  reset_n,
  // Sampled pin and mode
  input  wire logic                  level,
  input  wire pin_mux_pkg::edge_sel_e edgeSel,
  // Qualifying edge, one cycle
  output logic                       hit
);
  pin_mux_pkg::edge_state_s state;
  pin_mux_pkg::edge_state_s next_state;

  always_comb begin
    next_state.prev = level;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  always_comb begin
    unique case (edgeSel)
      pin_mux_pkg::EDGE_OFF:  hit = 1'b0;
      pin_mux_pkg::EDGE_RISE: hit = level & ~state.prev;
      pin_mux_pkg::EDGE_FALL: hit = ~level & state.prev;
      pin_mux_pkg::EDGE_BOTH: hit = level ^ state.prev;
    endcase
  end
endmodule

// ### testbench/pin_board_model.sv
// Board-side model of the five shared pins
`timescale 1ns/1ps
module pin_board_model (
  // Device drive
  input  wire pin_mux_pkg::pin_drive_s pinDrive,
  // Level the board puts on a pin the device has released
  input  wire logic [4:0]              boardLevel,
  // Resolved pin levels
  output logic [4:0]                   pinIn
);
  // Released pins follow the board, driven pins follow the device
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      pinIn[i] = pinDrive.enableN[i] ? boardLevel[i] : pinDrive.level[i];
    end
  end
endmodule

// ### testbench/tb.sv
// Self-checking bench for the shared pin controller
`timescale 1ns/1ps
module tb;
  logic                    ref_clk;
  logic                    reset_n;
  logic                    busSelectStrap;
  pin_mux_pkg::reg_req_s   regReq;
  logic [7:0]              regRdata;
  pin_mux_pkg::pnp_irq_s   pnpIrq;
  logic                    irq12Request;
  logic                    irq11Request;
  logic                    cardWakeup;
  logic [4:0]              pinIn;
  logic [4:0]              boardLevel;
  pin_mux_pkg::pin_drive_s pinDrive;
  logic                    transmitGo;
  logic                    externalControllerInterrupt;
  logic                    rdTaken;
  logic [7:0]              expQ[$];
  int                      n_errors;
  int                      num_checks;
  int                      cycles;

  multifunction_pin_control dut (.ref_clk(ref_clk), .reset_n(reset_n),
    .busSelectStrap(busSelectStrap), .regReq(regReq), .regRdata(regRdata), .pnpIrq(pnpIrq),
    .irq12Request(irq12Request), .irq11Request(irq11Request), .cardWakeup(cardWakeup),
    .pinIn(pinIn), .pinDrive(pinDrive), .transmitGo(transmitGo),
    .externalControllerInterrupt(externalControllerInterrupt));
  pin_board_model board (.pinDrive(pinDrive), .boardLevel(boardLevel), .pinIn(pinIn));

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("errors %0d checks %0d", n_errors, num_checks);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Read data stands only in the cycle after the strobe
  always @(posedge ref_clk) begin
    rdTaken <= regReq.rd;
    if (rdTaken) begin
      check("regRdata", {8'h00, regRdata}, {8'h00, expQ.pop_front()});
    end
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      close_out();
    end
  end

  task automatic regWrite(logic [7:0] a, logic [7:0] d);
    @(posedge ref_clk);
    regReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    regReq.wr <= 1'b0;
  endtask

  task automatic regRead(logic [7:0] a, logic [7:0] e);
    @(posedge ref_clk);
    regReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    expQ.push_back(e);
    @(posedge ref_clk);
    regReq.rd <= 1'b0;
  endtask

  task automatic settle();
    repeat (4) @(posedge ref_clk);
    #1;
  endtask

  task automatic pinsAre(logic [4:0] en, logic [4:0] lv);
    settle();
    check("enableN", {11'h000, pinDrive.enableN}, {11'h000, en});
    check("level", {11'h000, pinDrive.level & ~en}, {11'h000, lv & ~en});
  endtask

  task automatic doReset(logic strap);
    @(posedge ref_clk);
    reset_n <= 1'b0;
    busSelectStrap <= strap;
    repeat (8) @(posedge ref_clk);
    check("enableN in reset", {11'h000, pinDrive.enableN}, 16'h001f);
    check("flag in reset", {15'h0000, externalControllerInterrupt}, 16'h0000);
    reset_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
  endtask

  // Live levels placed at data bits 7, 4, 1 and 0
  function automatic logic [7:0] liveExp(logic [3:0] p);
    return {p[3], 2'b00, p[2], 2'b00, p[1], p[0]};
  endfunction

  initial begin
    logic [7:0] d;
    logic [4:0] en;
    logic [4:0] lv;
    regReq = '0;
    pnpIrq = '0;
    irq12Request = 1'b0;
    irq11Request = 1'b0;
    cardWakeup = 1'b0;
    boardLevel = 5'h00;
    busSelectStrap = 1'b0;
    reset_n = 1'b0;
    rdTaken = 1'b0;
    n_errors = 0;
    num_checks = 0;
    cycles = 0;
    void'($urandom(96));
    doReset(1'b0);
    regWrite(pin_mux_pkg::ADDR_USER_ENABLE, 8'h93);
    regWrite(pin_mux_pkg::ADDR_USER_DATA, 8'h93);
    regWrite(8'h40, 8'hff);
    regRead(8'h40, 8'h00);
    pinsAre(5'b11101, 5'b00010);
    for (int p = 0; p < 2; p++) begin
      for (int k = 1; k <= 2; k++) begin
        for (int r = 0; r < 2; r++) begin
          @(posedge ref_clk);
          pnpIrq <= '{select: p ? pin_mux_pkg::IRQ_SEL_11 : pin_mux_pkg::IRQ_SEL_12, kind: 2'(k)};
          irq12Request <= r[0];
          irq11Request <= r[0];
          en = 5'b11101;
          lv = 5'b00010;
          en[p ? 3 : 1] = (k == 1) ? ~r[0] : 1'b0;
          lv[p ? 3 : 1] = (k == 2) && r[0];
          pinsAre(en, lv);
        end
      end
    end
    regWrite(pin_mux_pkg::ADDR_FUNCTION_C, 8'h80);
    pinsAre(5'b11101, 5'b00010);
    @(posedge ref_clk);
    pnpIrq <= '0;
    boardLevel <= 5'($urandom());
    settle();
    regRead(pin_mux_pkg::ADDR_USER_DATA, liveExp({boardLevel[3:2], 1'b1, boardLevel[0]}));
    regRead(pin_mux_pkg::ADDR_MEM_IF_PIN, {7'h00, ~boardLevel[4]});
    doReset(1'b1);
    regWrite(pin_mux_pkg::ADDR_USER_ENABLE, 8'h93);
    for (int i = 0; i < 3; i++) begin
      d = 8'($urandom());
      regWrite(pin_mux_pkg::ADDR_USER_DATA, d);
      pinsAre(5'b00000, {1'b1, d[7], d[4], d[1], d[0]});
      regRead(pin_mux_pkg::ADDR_USER_DATA, liveExp({d[7], d[4], d[1], d[0]}));
      regRead(pin_mux_pkg::ADDR_MEM_IF_PIN, 8'h00);
    end
    regWrite(pin_mux_pkg::ADDR_FUNCTION_C, 8'h80);
    pinsAre(5'b01000, {1'b1, 1'b0, d[4], d[1], d[0]});
    regWrite(pin_mux_pkg::ADDR_MEM_IF_PIN, 8'h01);
    pinsAre(5'b01000, {1'b0, 1'b0, d[4], d[1], d[0]});
    regRead(pin_mux_pkg::ADDR_MEM_IF_PIN, 8'h01);
    regWrite(pin_mux_pkg::ADDR_FUNCTION_B, 8'h01);
    pinsAre(5'b01000, {1'b1, 1'b0, d[4], d[1], d[0]});
    @(posedge ref_clk);
    cardWakeup <= 1'b1;
    pinsAre(5'b01000, {1'b0, 1'b0, d[4], d[1], d[0]});
    @(posedge ref_clk);
    cardWakeup <= 1'b0;
    settle();
    @(posedge ref_clk);
    cardWakeup <= 1'b1;
    pinsAre(5'b01000, {1'b1, 1'b0, d[4], d[1], d[0]});
    regRead(pin_mux_pkg::ADDR_MEM_IF_PIN, 8'h00);
    regWrite(pin_mux_pkg::ADDR_MEM_IF_PIN, 8'h01);
    pinsAre(5'b01000, {1'b0, 1'b0, d[4], d[1], d[0]});
    regWrite(pin_mux_pkg::ADDR_USER_ENABLE, 8'h91);
    regWrite(pin_mux_pkg::ADDR_TX_CONTROL, 8'h01);
    settle();
    check("transmitGo ungated", {15'h0000, transmitGo}, 16'h0001);
    regWrite(pin_mux_pkg::ADDR_CONFIG_A, 8'h01);
    for (int v = 0; v < 2; v++) begin
      @(posedge ref_clk);
      boardLevel[1] <= v[0];
      settle();
      check("transmitGo gated", {15'h0000, transmitGo}, 16'(v));
    end
    for (int e = 0; e < 4; e++) begin
      regWrite(pin_mux_pkg::ADDR_CONFIG_A, {3'b000, 2'(e), 3'b000});
      @(posedge ref_clk);
      boardLevel[1] <= 1'b0;
      settle();
      regWrite(pin_mux_pkg::ADDR_INT_STATUS, 8'h08);
      for (int v = 1; v >= 0; v--) begin
        @(posedge ref_clk);
        boardLevel[1] <= v[0];
        settle();
        lv[0] = v ? e[0] : e[1];
        check("edge flag", {15'h0000, externalControllerInterrupt}, {15'h0000, lv[0]});
        regRead(pin_mux_pkg::ADDR_INT_STATUS, {4'h0, lv[0], 3'b000});
        regWrite(pin_mux_pkg::ADDR_INT_STATUS, 8'h08);
        settle();
        check("flag once", {15'h0000, externalControllerInterrupt}, 16'h0000);
      end
    end
    settle();
    check("reads left", 16'(expQ.size()), 16'h0000);
    close_out();
  end
endmodule
